// ===== inc/gpmux_map.vh
// Register map, field positions and reset values of the pin-function multiplexer
// Behaviour
// - Input level register C is read-only: pins 21..16 in bits 5..0, 7..6 zero.
// - Fixed output low register drives outputs 0..7 and resets to all ones.
// - Fixed output high register drives outputs 8..11, upper nibble zero, resets 0x0F.
// - IRQ route bit puts interrupts on outputs 0..4, 7 and serial IRQ pin.
// - Select bits 3 and 1 choose PS/2, serial receive or serial transmit on GP20/21.
// - Non-PS/2 function on GP20/21 holds PS/2 inputs high internally.
// - A disabled PS/2 channel sees its inputs held high.
// - IR bypass bit connects IR pins to IR data register bits.
// - PWM route bit puts both PWM outputs on outputs 10 and 11.
// - Floppy bit puts drive select 1 and motor 1 on outputs 5 and 6.
// - Gate-A20 route bit puts the gate-A20 output on GP17.
// - IR COM route bit connects GP8/GP9 to IR COM receive and transmit.
// - Scan extra bit turns GP4 and GP5 into scan outputs 14 and 15.
// - Output 8 carries DMA request 2, else CPU reset or fixed output 8.
// - Scan-12 pin carries scan 12, or CPU reset/fixed output 8 when swapped.
// - Swap bit moves GP18 to scan-13 pin, GP18 pin becomes DMA acknowledge 2.
// - Firmware makes GP18 input; device passes its level to DMA acknowledge 2.
// - DMA3 bit puts DMA request 3 on output 9, acknowledge 3 on GP19.
// - UART2 modem bit puts CTS, DTR, DSR, DCD, RI on GP11..GP15.
// - Field 5:4 selects GP6: GPIO, Infrared_mode_out out, fast IR receive, reserved.
// - Field 7:6 selects GP10: GPIO, Infrared_mode_out out, fast IR receive, UART2 RTS.
// - Third mux register holds swap bit at bit 1, bits 7..2 read zero.
// - In bypass, IR data bit 0 drives IR transmit, bit 1 reads IR receive.
`ifndef GPMUX_MAP_VH
`define GPMUX_MAP_VH
`define GPMUX_OFS_GPIO_HI_IN    16'h7F20
`define GPMUX_OFS_FIXED_OUT_LO  16'h7F22
`define GPMUX_OFS_FIXED_OUT_HI  16'h7F23
`define GPMUX_OFS_DED_IN        16'h7F24
`define GPMUX_OFS_SEL_THREE     16'h7F30
`define GPMUX_OFS_SEL_ONE       16'h7F3D
`define GPMUX_OFS_SEL_TWO       16'h7F40
`define GPMUX_IDX_IR_DATA       8'h98
`define GPMUX_RST_FIXED_OUT_LO  8'hFF
`define GPMUX_RST_FIXED_OUT_HI  4'hF
`define GPMUX_RST_SEL           8'h00
`define GPMUX_RST_SEL_THREE     2'h0
`define GPMUX_RST_IR_DATA       1'h0
`define GPMUX_B1_IRQ_ROUTE      0
`define GPMUX_B1_PS2_ROUTE      1
`define GPMUX_B1_IR_BYPASS      2
`define GPMUX_B1_SER_TX         3
`define GPMUX_B1_PWM            4
`define GPMUX_B1_FLOPPY         5
`define GPMUX_B1_GATE_A20       6
`define GPMUX_B1_IR_COM         7
`define GPMUX_B2_SCAN_EXTRA     0
`define GPMUX_B2_DMA2           1
`define GPMUX_B2_DMA3           2
`define GPMUX_B2_UART2_MODEM    3
`define GPMUX_B2_GP6_LO         4
`define GPMUX_B2_GP10_LO        6
`define GPMUX_B3_SCAN_SWAP      1
`define GPMUX_FN_GPIO           2'h0
`define GPMUX_FN_INFRARED_MODE_OUT        2'h1
`define GPMUX_FN_FAST_IR        2'h2
`define GPMUX_FN_RTS            2'h3
`endif

// ===== tb/gpmux_board.sv
// Board model: pads with pull-ups and external drivers
`default_nettype none
module gpmux_board (
	// Pads as the device drives them
	input  wire logic [21:0] gpio_pin_out,
	input  wire logic [21:0] gpio_pin_oe,
	input  wire logic        scan13_pin_out,
	input  wire logic        scan13_pin_oe,
	// External parts: enable and level per pad, scan-13 pad on top
	input  wire logic [22:0] ext_en,
	input  wire logic [22:0] ext_val,
	// Resolved pad levels
	output logic      [21:0] gpio_pin_in,
	output logic             scan13_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [22:0] oe = {scan13_pin_oe, gpio_pin_oe};
	wire [22:0] dv = {scan13_pin_out, gpio_pin_out};
	// Device drive wins, then the external part, else the weak pull-up
	assign {scan13_pin_in, gpio_pin_in} = (oe & dv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
endmodule
`default_nettype wire

// ===== tb/gpmux_properties.sv
// Checker of pin routing against shadow copies of the select registers
`default_nettype none
module gpmux_properties (
	// Clock, reset and register buses
	input wire logic        clk_sys, arst_n, mem_wr, mem_rd, host_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata, mem_rdata, host_idx, host_wdata,
	// Pins
	input wire logic [11:0] out_pin,
	input wire logic [21:0] gpio_pin_out,
	input wire logic        scan_out_twelve_pin, infrared_tx_pin,
	// Unit signals
	input wire logic        irctl_tx, irq_fdc, irq8_n, irq_pp, irq_mouse, irq_kbd, sys_mgmt_irq_n, cpu_reset,
	input wire logic        pulse_out_zero, pulse_out_one, floppy_drive_sel1_n, floppy_motor1_n, addr20_gate,
	input wire logic        dma_req_two, dma_req_three, scan_out_twelve, scan_out_fourteen, scan_out_fifteen,
	input wire logic        uart2_term_ready_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sel1_reg, sel2_reg, lo_reg;
	logic [3:0] hi_reg;
	logic [1:0] sel3_reg;
	logic       ir_reg, armed_reg;
	wire        eight_src = sel1_reg[6] ? cpu_reset : hi_reg[0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// Shadow registers, written on the same edges as the design's
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sel1_reg <= 8'h00;
			sel2_reg <= 8'h00;
			sel3_reg <= 2'h0;
			lo_reg   <= 8'hFF;
			hi_reg   <= 4'hF;
			ir_reg   <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			if (mem_wr && mem_addr == 16'h7F3D) sel1_reg <= mem_wdata;
			if (mem_wr && mem_addr == 16'h7F40) sel2_reg <= mem_wdata;
			if (mem_wr && mem_addr == 16'h7F30) sel3_reg <= mem_wdata[1:0];
			if (mem_wr && mem_addr == 16'h7F22) lo_reg <= mem_wdata;
			if (mem_wr && mem_addr == 16'h7F23) hi_reg <= mem_wdata[3:0];
			if (host_wr && host_idx == 8'h98) ir_reg <= host_wdata[0];
			armed_reg <= 1'b1; // Pins reset apart from their sources, so skip the first edge
		end
	end
	a_irq_route_pins: assert property ({out_pin[7], out_pin[4:0]} == $past(sel1_reg[0] ?
		{sys_mgmt_irq_n, irq_kbd, irq_mouse, irq_pp, irq8_n, irq_fdc} : {lo_reg[7], lo_reg[4:0]}))
		else $error("irq routing differs");
	a_pwm_route_pins: assert property (sel1_reg[4] |=> out_pin[11:10] == $past({pulse_out_one, pulse_out_zero}))
		else $error("pwm routing differs");
	a_floppy_pins: assert property (out_pin[6:5] == $past(sel1_reg[5] ?
		{floppy_motor1_n, floppy_drive_sel1_n} : lo_reg[6:5])) else $error("floppy routing differs");
	a_out_eight_pick: assert property (out_pin[8] == $past(sel2_reg[1] ? dma_req_two : eight_src))
		else $error("output eight differs");
	a_scan12_swap: assert property (armed_reg |->
		scan_out_twelve_pin == $past(sel3_reg[1] ? eight_src : scan_out_twelve))
		else $error("scan twelve pin differs");
	a_dma3_request: assert property (sel2_reg[2] |=> out_pin[9] == $past(dma_req_three))
		else $error("dma three request differs");
	a_gate_a20_pin: assert property (sel1_reg[6] |=> gpio_pin_out[17] == $past(addr20_gate))
		else $error("gate a20 pin differs");
	a_scan_extra_pins: assert property (sel2_reg[0] |=>
		gpio_pin_out[5:4] == $past({scan_out_fifteen, scan_out_fourteen})) else $error("scan extra differs");
	a_ir_bypass_tx: assert property (infrared_tx_pin == $past(sel1_reg[2] ? ir_reg : irctl_tx))
		else $error("ir transmit pin differs");
	a_uart2_dtr_pin: assert property (sel2_reg[3] |=> gpio_pin_out[12] == $past(uart2_term_ready_n))
		else $error("uart2 ready pin differs");
	a_level_top_zero: assert property (mem_rd && mem_addr == 16'h7F20 |-> ##2 mem_rdata[7:6] == 2'b00)
		else $error("level register top bits set");
	a_high_nibble_zero: assert property (mem_rd && mem_addr == 16'h7F23 |-> ##2 mem_rdata[7:4] == 4'h0)
		else $error("fixed high upper bits set");
	// Main routing scenarios reached
	c_irq_route: cover property (sel1_reg[0]);
	c_swap_reset: cover property (sel3_reg[1] && sel1_reg[6]);
	c_dma_two: cover property (sel2_reg[1]);
endmodule
bind gpmux_top gpmux_properties chk (.*);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the pin-function multiplexer
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, arst_n, mem_wr, mem_rd, host_wr, host_rd, infrared_rx_pin;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, host_idx, host_wdata, in_pin;
	logic [21:0] gpio_dir, gpio_out;
	logic [22:0] ext_en, ext_val;
	logic        irq_fdc, irq8_n, irq_pp, irq_mouse, irq_kbd, sys_mgmt_irq_n, uart1_irq3, serial_irq_drive;
	logic        serial_irq_drive_en, ps2_chan_en, kbd_port_clock_low, kbd_port_data_low, mcu_serial_tx, irctl_tx;
	logic        ir_com_tx, infrared_mode_out, pulse_out_zero, pulse_out_one, floppy_drive_sel1_n;
	logic        floppy_motor1_n, addr20_gate, cpu_reset, dma_req_two, dma_req_three, scan_out_twelve;
	logic        scan_out_thirteen, scan_out_fourteen, scan_out_fifteen, uart2_term_ready_n, uart2_req_to_send_n;
	wire  [21:0] gpio_level, gpio_pin_in, gpio_pin_out, gpio_pin_oe;
	wire  [11:0] out_pin;
	wire  [7:0]  mem_rdata, host_rdata;
	wire         scan_out_twelve_pin, scan13_pin_in, scan13_pin_out, scan13_pin_oe, serial_irq_line_out;
	wire         serial_irq_line_oe, infrared_tx_pin, kbd_port_clock, kbd_port_data, mcu_serial_rx, irctl_rx;
	wire         ir_com_rx, fast_infrared_rx, dma_ack_two_n, dma_ack_three_n, uart2_clear_to_send_n;
	wire         uart2_set_ready_n, uart2_carrier_n, uart2_ring_n;
	int          fails = 0;
	int          tests_run = 0;
	int          cycles = 0;
	gpmux_top dut (.*);
	gpmux_board board (.*);
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic complete_run();
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			complete_run();
		end
	end
	task automatic chk(input logic [11:0] g, e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// All unit inputs at once
	task automatic u(input logic [29:0] v);
		{irq_fdc, irq8_n, irq_pp, irq_mouse, irq_kbd, sys_mgmt_irq_n, uart1_irq3, serial_irq_drive,
			serial_irq_drive_en, ps2_chan_en, kbd_port_clock_low, kbd_port_data_low, mcu_serial_tx, irctl_tx,
			ir_com_tx, infrared_mode_out, pulse_out_zero, pulse_out_one, floppy_drive_sel1_n, floppy_motor1_n,
			addr20_gate, cpu_reset, dma_req_two, dma_req_three, scan_out_twelve, scan_out_thirteen,
			scan_out_fourteen, scan_out_fifteen, uart2_term_ready_n, uart2_req_to_send_n} = v;
	endtask
	// Register write: h selects the host index port
	task automatic wr(input logic h, input logic [15:0] a, input logic [7:0] d);
		w(1);
		{host_wr, mem_wr} = h ? 2'b10 : 2'b01;
		{host_idx, mem_addr, host_wdata, mem_wdata} = {a[7:0], a, d, d};
		w(1);
		{host_wr, mem_wr} = 2'b00;
	endtask
	task automatic rd(input logic h, input logic [15:0] a, input logic [7:0] e);
		w(1);
		{host_rd, mem_rd} = h ? 2'b10 : 2'b01;
		{host_idx, mem_addr} = {a[7:0], a};
		w(1);
		{host_rd, mem_rd} = 2'b00;
		w(1);
		chk(h ? host_rdata : mem_rdata, e);
	endtask
	initial begin
		{mem_wr, mem_rd, host_wr, host_rd, mem_addr, mem_wdata, host_idx, host_wdata} = 44'h0;
		{gpio_dir, gpio_out, in_pin, infrared_rx_pin, ext_en, ext_val} = 99'h0;
		u(30'h0);
		arst_n = 1'b0;
		w(8);
		arst_n = 1'b1;
		w(1);
		chk(out_pin, 12'hFFF);
		rd(0, 16'h7F22, 8'hFF);
		rd(0, 16'h7F23, 8'h0F);
		rd(0, 16'h7F3D, 8'h00);
		rd(0, 16'h7F40, 8'h00);
		rd(0, 16'h7F30, 8'h00);
		rd(0, 16'h7F21, 8'h00);
		wr(0, 16'h7F23, 8'hF5);
		rd(0, 16'h7F23, 8'h05);
		wr(0, 16'h7F30, 8'hFE);
		rd(0, 16'h7F30, 8'h02);
		wr(0, 16'h7F30, 8'h00);
		wr(0, 16'h7F20, 8'hFF);
		// Level registers through the pad filter
		ext_en = 23'h7FFFFF;
		ext_val = 23'h150000;
		in_pin = 8'hC3;
		w(7);
		rd(0, 16'h7F20, 8'h15);
		rd(0, 16'h7F24, 8'hC3);
		// Fixed outputs and interrupt routing
		wr(0, 16'h7F22, 8'h5A);
		w(2);
		chk(out_pin[7:0], 8'h5A);
		u(30'h2AAAAAAA);
		wr(0, 16'h7F3D, 8'h01);
		w(2);
		chk({out_pin[7], out_pin[4:0], serial_irq_line_out, serial_irq_line_oe}, 8'h57);
		// Output pins under PWM, floppy, DMA, gate-A20, swap and scan extra selects, both polarities of the sources
		wr(0, 16'h7F3D, 8'h71);
		wr(0, 16'h7F40, 8'h07);
		wr(0, 16'h7F30, 8'h02);
		for (int p = 0; p < 2; p++) begin
			u(p ? 30'h15555555 : 30'h2AAAAAAA);
			w(2);
			chk({out_pin[11:8], out_pin[6:5], scan_out_twelve_pin, gpio_pin_out[17], gpio_pin_out[5:4]},
				p ? 10'h2AA : 10'h155);
		end
		ext_val = 23'h400000;
		w(7);
		chk({dma_ack_two_n, dma_ack_three_n, gpio_level[18]}, 3'b001);
		wr(0, 16'h7F30, 8'h00);
		ext_val = 23'h040000;
		// Pin 18 stays an input so its level reaches the acknowledge
		gpio_dir[18] = 1'b0;
		w(7);
		chk({dma_ack_two_n, gpio_level[18], scan13_pin_out}, 3'b111);
		// PS/2 pins, channel enable and serial port
		wr(0, 16'h7F3D, 8'h02);
		// Clock line pulled low by the device, data line high from the board
		{ps2_chan_en, kbd_port_clock_low, kbd_port_data_low} = 3'b110;
		ext_val = 23'h200000;
		w(7);
		chk({kbd_port_clock, kbd_port_data}, 2'b01);
		ps2_chan_en = 1'b0;
		w(2);
		chk({kbd_port_clock, kbd_port_data}, 2'b11);
		{ps2_chan_en, mcu_serial_tx} = 2'b11;
		ext_val = 23'h000000;
		// Pin 21 made an output for serial transmit
		gpio_dir[21] = 1'b1;
		wr(0, 16'h7F3D, 8'h08);
		w(7);
		chk({kbd_port_clock, kbd_port_data, gpio_pin_oe[21], gpio_pin_out[21], mcu_serial_rx}, 5'h1E);
		gpio_dir = 22'h0;
		// IR bypass and IR COM routing
		wr(0, 16'h7F3D, 8'h84);
		wr(1, 16'h0098, 8'hFF);
		{infrared_rx_pin, ir_com_tx, irctl_tx} = 3'b110;
		w(7);
		chk({infrared_tx_pin, irctl_rx, gpio_pin_out[9], ir_com_rx}, 4'hE);
		rd(1, 16'h0098, 8'h03);
		// GPIO6 and GPIO10 codes with second UART modem lines
		uart2_req_to_send_n = 1'b0;
		ext_val = 23'h004000;
		for (int c = 1; c < 4; c++) begin
			wr(0, 16'h7F40, {c[1:0], c[1:0], 4'h8});
			w(7);
			case (c)
				1: chk({gpio_pin_out[6], gpio_pin_out[10]}, 2'b11);
				2: chk(fast_infrared_rx, 1'b0);
				default: chk({uart2_ring_n, uart2_carrier_n, uart2_set_ready_n, uart2_clear_to_send_n,
					gpio_pin_out[12], gpio_pin_out[10]}, 6'h10);
			endcase
		end
		complete_run();
	end
endmodule
`default_nettype wire

// ===== verilog/gpmux_top.v
// Pin-function multiplexer with fixed output and pin level registers
`include "gpmux_map.vh"
`default_nettype none
module gpmux_top (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// Controller memory-mapped access
	input  wire [15:0] mem_addr,
	input  wire        mem_wr,
	input  wire        mem_rd,
	input  wire [7:0]  mem_wdata,
	output reg  [7:0]  mem_rdata,
	// Host indexed access
	input  wire [7:0]  host_idx,
	input  wire        host_wr,
	input  wire        host_rd,
	input  wire [7:0]  host_wdata,
	output reg  [7:0]  host_rdata,
	// GPIO register values from the direction and output registers
	input  wire [21:0] gpio_dir,
	input  wire [21:0] gpio_out,
	output reg  [21:0] gpio_level,
	// GPIO pins
	input  wire [21:0] gpio_pin_in,
	output reg  [21:0] gpio_pin_out,
	output reg  [21:0] gpio_pin_oe,
	// Dedicated pins
	input  wire [7:0]  in_pin,
	output reg  [11:0] out_pin,
	output reg         scan_out_twelve_pin,
	input  wire        scan13_pin_in,
	output reg         scan13_pin_out,
	output reg         scan13_pin_oe,
	output reg         serial_irq_line_out,
	output reg         serial_irq_line_oe,
	output reg         infrared_tx_pin,
	input  wire        infrared_rx_pin,
	// Interrupt sources
	input  wire        irq_fdc,
	input  wire        irq8_n,
	input  wire        irq_pp,
	input  wire        irq_mouse,
	input  wire        irq_kbd,
	input  wire        sys_mgmt_irq_n,
	input  wire        uart1_irq3,
	input  wire        serial_irq_drive,
	input  wire        serial_irq_drive_en,
	// PS/2 and controller serial port
	input  wire        ps2_chan_en,
	input  wire        kbd_port_clock_low,
	input  wire        kbd_port_data_low,
	output reg         kbd_port_clock,
	output reg         kbd_port_data,
	input  wire        mcu_serial_tx,
	output reg         mcu_serial_rx,
	// IR controller
	input  wire        irctl_tx,
	output reg         irctl_rx,
	input  wire        ir_com_tx,
	output reg         ir_com_rx,
	input  wire        infrared_mode_out,
	output reg         fast_infrared_rx,
	// Other units
	input  wire        pulse_out_zero,
	input  wire        pulse_out_one,
	input  wire        floppy_drive_sel1_n,
	input  wire        floppy_motor1_n,
	input  wire        addr20_gate,
	input  wire        cpu_reset,
	input  wire        dma_req_two,
	input  wire        dma_req_three,
	output reg         dma_ack_two_n,
	output reg         dma_ack_three_n,
	input  wire        scan_out_twelve,
	input  wire        scan_out_thirteen,
	input  wire        scan_out_fourteen,
	input  wire        scan_out_fifteen,
	// Second UART modem lines
	input  wire        uart2_term_ready_n,
	input  wire        uart2_req_to_send_n,
	output reg         uart2_clear_to_send_n,
	output reg         uart2_set_ready_n,
	output reg         uart2_carrier_n,
	output reg         uart2_ring_n
);

	// Control registers
	reg [7:0] fixed_output_low_reg, sel_one_reg, sel_two_reg;
	reg [3:0] fixed_output_high_reg;
	reg [1:0] sel_three_reg;
	reg       infrared_tx_bit_reg;
	// Pin synchroniser stages and filtered level
	reg [31:0] sync1_reg, sync2_reg, sync3_reg, lvl_reg;

	// Select fields
	wire irq_route_sel           = sel_one_reg[`GPMUX_B1_IRQ_ROUTE];
	wire ps2_route_sel           = sel_one_reg[`GPMUX_B1_PS2_ROUTE];
	wire ir_bypass_sel           = sel_one_reg[`GPMUX_B1_IR_BYPASS];
	wire serial_tx_route_sel     = sel_one_reg[`GPMUX_B1_SER_TX];
	wire pwm_route_sel           = sel_one_reg[`GPMUX_B1_PWM];
	wire floppy_second_drive_sel = sel_one_reg[`GPMUX_B1_FLOPPY];
	wire gate_a20_route_sel      = sel_one_reg[`GPMUX_B1_GATE_A20];
	wire ir_com_route_sel        = sel_one_reg[`GPMUX_B1_IR_COM];
	wire scan_extra_route_sel    = sel_two_reg[`GPMUX_B2_SCAN_EXTRA];
	wire dma2_route_sel          = sel_two_reg[`GPMUX_B2_DMA2];
	wire dma3_route_sel          = sel_two_reg[`GPMUX_B2_DMA3];
	wire uart2_modem_route_sel   = sel_two_reg[`GPMUX_B2_UART2_MODEM];
	wire [1:0] gp6_fn            = sel_two_reg[`GPMUX_B2_GP6_LO+1:`GPMUX_B2_GP6_LO];
	wire [1:0] gp10_fn           = sel_two_reg[`GPMUX_B2_GP10_LO+1:`GPMUX_B2_GP10_LO];
	wire scan_swap_sel           = sel_three_reg[`GPMUX_B3_SCAN_SWAP];
	wire fixed_output_eight      = fixed_output_high_reg[0];

	// Level changes once the second and third stages agree
	wire [31:0] lvl_next  = (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & lvl_reg);
	wire [21:0] gp_lvl    = lvl_reg[21:0];
	wire [7:0]  ded_lvl   = lvl_reg[29:22];
	wire        ir_rx_lvl = lvl_reg[30];
	wire        s13_lvl   = lvl_reg[31];

	// Next values of pins and unit inputs
	reg [21:0] gpio_level_next;
	reg [21:0] gpio_pin_out_next;
	reg [21:0] gpio_pin_oe_next;
	reg [11:0] out_pin_next;
	reg [3:0]  modem_next;
	reg        scan12_next, s13_out_next, s13_oe_next, ser_irq_out_next, ser_irq_oe_next, infrared_tx_bit_pin_next;
	reg        kbd_clk_next, kbd_dat_next, ser_rx_next, irctl_rx_next, ir_com_rx_next, fir_next;
	reg        ack2_next, ack3_next, cpu_rst_or_fixed8, ps2_live;

	// Pin function routing
	always @* begin
		gpio_pin_out_next = gpio_out;
		gpio_pin_oe_next  = gpio_dir;
		gpio_level_next   = gp_lvl;
		out_pin_next      = {fixed_output_high_reg, fixed_output_low_reg};
		cpu_rst_or_fixed8 = gate_a20_route_sel ? cpu_reset : fixed_output_eight;
		ps2_live          = ps2_route_sel & ps2_chan_en;
		if (irq_route_sel) begin
			out_pin_next[4:0] = {irq_kbd, irq_mouse, irq_pp, irq8_n, irq_fdc};
			out_pin_next[7]   = sys_mgmt_irq_n;
		end
		ser_irq_out_next = irq_route_sel ? uart1_irq3 : serial_irq_drive;
		ser_irq_oe_next  = irq_route_sel ? 1'b1 : serial_irq_drive_en;
		if (floppy_second_drive_sel) begin
			out_pin_next[5] = floppy_drive_sel1_n;
			out_pin_next[6] = floppy_motor1_n;
		end
		if (dma2_route_sel)
			out_pin_next[8] = dma_req_two;
		else
			out_pin_next[8] = cpu_rst_or_fixed8;
		if (dma3_route_sel) begin
			out_pin_next[9]     = dma_req_three;
			gpio_pin_oe_next[19] = 1'b0;
		end
		ack3_next = dma3_route_sel ? gp_lvl[19] : 1'b1;
		if (pwm_route_sel)
			out_pin_next[11:10] = {pulse_out_one, pulse_out_zero};
		scan12_next = scan_swap_sel ? cpu_rst_or_fixed8 : scan_out_twelve;
		// GP18 moves to scan 13 pin
		if (scan_swap_sel) begin
			s13_out_next         = gpio_out[18];
			s13_oe_next          = gpio_dir[18];
			gpio_pin_oe_next[18] = 1'b0;
			gpio_level_next[18]  = s13_lvl;
		end else begin
			s13_out_next = scan_out_thirteen;
			s13_oe_next  = 1'b1;
		end
		// acknowledge 2 from the GP18 pin
		ack2_next = gp_lvl[18];
		if (gate_a20_route_sel) begin
			gpio_pin_out_next[17] = addr20_gate;
			gpio_pin_oe_next[17]  = 1'b1;
		end
		if (ps2_route_sel) begin
			gpio_pin_out_next[21:20] = 2'h0;
			gpio_pin_oe_next[21:20]  = {kbd_port_data_low, kbd_port_clock_low};
		end else if (serial_tx_route_sel) begin
			gpio_pin_out_next[21] = mcu_serial_tx;
		end
		// PS/2 inputs held high off function
		kbd_clk_next = ps2_live ? gp_lvl[20] : 1'b1;
		kbd_dat_next = ps2_live ? gp_lvl[21] : 1'b1;
		ser_rx_next  = ps2_route_sel ? 1'b1 : gp_lvl[20];
		// IR data bit to transmit pin
		infrared_tx_bit_pin_next = ir_bypass_sel ? infrared_tx_bit_reg : irctl_tx;
		irctl_rx_next  = ir_bypass_sel ? 1'b1 : ir_rx_lvl;
		if (ir_com_route_sel) begin
			gpio_pin_oe_next[8]  = 1'b0;
			gpio_pin_out_next[9] = ir_com_tx;
			gpio_pin_oe_next[9]  = 1'b1;
		end
		ir_com_rx_next = ir_com_route_sel ? gp_lvl[8] : 1'b1;
		if (scan_extra_route_sel) begin
			gpio_pin_out_next[5:4] = {scan_out_fifteen, scan_out_fourteen};
			gpio_pin_oe_next[5:4]  = 2'h3;
		end
		if (uart2_modem_route_sel) begin
			gpio_pin_oe_next[15:11] = 5'h02;
			gpio_pin_out_next[12]   = uart2_term_ready_n;
			modem_next = {gp_lvl[15], gp_lvl[14], gp_lvl[13], gp_lvl[11]};
		end else begin
			modem_next = 4'hF;
		end
		fir_next = 1'b1;
		case (gp6_fn)
			`GPMUX_FN_INFRARED_MODE_OUT: begin
				gpio_pin_out_next[6] = infrared_mode_out;
				gpio_pin_oe_next[6]  = 1'b1;
			end
			`GPMUX_FN_FAST_IR: begin
				gpio_pin_oe_next[6] = 1'b0;
				fir_next            = gp_lvl[6];
			end
			default: gpio_pin_oe_next[6] = gpio_dir[6];
		endcase
		case (gp10_fn)
			`GPMUX_FN_INFRARED_MODE_OUT: begin
				gpio_pin_out_next[10] = infrared_mode_out;
				gpio_pin_oe_next[10]  = 1'b1;
			end
			`GPMUX_FN_FAST_IR: begin
				gpio_pin_oe_next[10] = 1'b0;
				if (gp6_fn != `GPMUX_FN_FAST_IR)
					fir_next = gp_lvl[10];
			end
			`GPMUX_FN_RTS: begin
				gpio_pin_out_next[10] = uart2_req_to_send_n;
				gpio_pin_oe_next[10]  = 1'b1;
			end
			default: gpio_pin_oe_next[10] = gpio_dir[10];
		endcase
	end

	// Register read data
	reg [7:0] rd_next;
	always @* begin
		case (mem_addr)
			`GPMUX_OFS_GPIO_HI_IN:   rd_next = {2'h0, gpio_level[21:16]};
			`GPMUX_OFS_FIXED_OUT_LO: rd_next = fixed_output_low_reg;
			`GPMUX_OFS_FIXED_OUT_HI: rd_next = {4'h0, fixed_output_high_reg};
			`GPMUX_OFS_DED_IN:       rd_next = ded_lvl;
			// swap bit with zero upper bits
			`GPMUX_OFS_SEL_THREE:    rd_next = {6'h00, sel_three_reg};
			`GPMUX_OFS_SEL_ONE:      rd_next = sel_one_reg;
			`GPMUX_OFS_SEL_TWO:      rd_next = sel_two_reg;
			default:                 rd_next = 8'h00;
		endcase
	end

	// Register writes and read captures
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fixed_output_low_reg  <= `GPMUX_RST_FIXED_OUT_LO;
			fixed_output_high_reg <= `GPMUX_RST_FIXED_OUT_HI;
			sel_one_reg           <= `GPMUX_RST_SEL;
			sel_two_reg           <= `GPMUX_RST_SEL;
			sel_three_reg         <= `GPMUX_RST_SEL_THREE;
			infrared_tx_bit_reg   <= `GPMUX_RST_IR_DATA;
			mem_rdata             <= 8'h00;
			host_rdata            <= 8'h00;
		end else begin
			if (mem_wr) begin
				case (mem_addr)
					`GPMUX_OFS_FIXED_OUT_LO: fixed_output_low_reg  <= mem_wdata;
					`GPMUX_OFS_FIXED_OUT_HI: fixed_output_high_reg <= mem_wdata[3:0];
					`GPMUX_OFS_SEL_ONE:      sel_one_reg           <= mem_wdata;
					`GPMUX_OFS_SEL_TWO:      sel_two_reg           <= mem_wdata;
					`GPMUX_OFS_SEL_THREE:    sel_three_reg         <= mem_wdata[1:0];
					default: ;
				endcase
			end
			if (mem_rd)
				mem_rdata <= rd_next;
			// IR data register on the host index
			if (host_wr && host_idx == `GPMUX_IDX_IR_DATA)
				infrared_tx_bit_reg <= host_wdata[0];
			if (host_rd)
				host_rdata <= (host_idx == `GPMUX_IDX_IR_DATA) ?
					{6'h00, ir_rx_lvl, infrared_tx_bit_reg} : 8'h00;
		end
	end

	// Pin synchroniser and registered pin outputs
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg             <= 32'h00000000;
			sync2_reg             <= 32'h00000000;
			sync3_reg             <= 32'h00000000;
			lvl_reg               <= 32'h00000000;
			gpio_level            <= 22'h000000;
			gpio_pin_out          <= 22'h000000;
			gpio_pin_oe           <= 22'h000000;
			out_pin               <= 12'hFFF;
			scan_out_twelve_pin   <= 1'b1;
			scan13_pin_out        <= 1'b1;
			scan13_pin_oe         <= 1'b0;
			serial_irq_line_out   <= 1'b1;
			serial_irq_line_oe    <= 1'b0;
			infrared_tx_pin       <= 1'b0;
			kbd_port_clock        <= 1'b1;
			kbd_port_data         <= 1'b1;
			mcu_serial_rx         <= 1'b1;
			irctl_rx              <= 1'b1;
			ir_com_rx             <= 1'b1;
			fast_infrared_rx      <= 1'b1;
			dma_ack_two_n         <= 1'b1;
			dma_ack_three_n       <= 1'b1;
			uart2_clear_to_send_n <= 1'b1;
			uart2_set_ready_n     <= 1'b1;
			uart2_carrier_n       <= 1'b1;
			uart2_ring_n          <= 1'b1;
		end else begin
			sync1_reg             <= {scan13_pin_in, infrared_rx_pin, in_pin, gpio_pin_in};
			sync2_reg             <= sync1_reg;
			sync3_reg             <= sync2_reg;
			lvl_reg               <= lvl_next;
			gpio_level            <= gpio_level_next;
			gpio_pin_out          <= gpio_pin_out_next;
			gpio_pin_oe           <= gpio_pin_oe_next;
			out_pin               <= out_pin_next;
			scan_out_twelve_pin   <= scan12_next;
			scan13_pin_out        <= s13_out_next;
			scan13_pin_oe         <= s13_oe_next;
			serial_irq_line_out   <= ser_irq_out_next;
			serial_irq_line_oe    <= ser_irq_oe_next;
			infrared_tx_pin       <= infrared_tx_bit_pin_next;
			kbd_port_clock        <= kbd_clk_next;
			kbd_port_data         <= kbd_dat_next;
			mcu_serial_rx         <= ser_rx_next;
			irctl_rx              <= irctl_rx_next;
			ir_com_rx             <= ir_com_rx_next;
			fast_infrared_rx      <= fir_next;
			dma_ack_two_n         <= ack2_next;
			dma_ack_three_n       <= ack3_next;
			uart2_clear_to_send_n <= modem_next[0];
			uart2_set_ready_n     <= modem_next[1];
			uart2_carrier_n       <= modem_next[2];
			uart2_ring_n          <= modem_next[3];
		end
	end

endmodule
`default_nettype wire
